/* hw/dcsw_pkg.sv */
package dcsw_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [3:0] DCSW_OFS_CMD = 4'h0;
  localparam logic [3:0] DCSW_OFS_STATE = 4'h4;
  localparam logic [3:0] DCSW_OFS_CFG = 4'h8;

  // Command word bit positions
  localparam int DCSW_C_PRESET_LO = 0;
  localparam int DCSW_C_PRESET_HI = 1;
  localparam int DCSW_C_RAMP_NOT_DC = 2;
  localparam int DCSW_C_NO_COAST = 3;
  localparam int DCSW_C_NO_QSTOP = 4;
  localparam int DCSW_C_NO_FREEZE = 5;
  localparam int DCSW_C_START = 6;
  localparam int DCSW_C_RESET = 7;
  localparam int DCSW_C_JOG = 8;
  localparam int DCSW_C_RAMP2 = 9;
  localparam int DCSW_C_VALID = 10;
  localparam int DCSW_C_RELAY1 = 11;
  localparam int DCSW_C_RELAY2 = 12;
  localparam int DCSW_C_SETUP_LO = 13;
  localparam int DCSW_C_SETUP_HI = 14;
  localparam int DCSW_C_REVERSE = 15;

  // State word bit positions
  localparam int DCSW_S_CTRL_READY = 0;
  localparam int DCSW_S_DRIVE_READY = 1;
  localparam int DCSW_S_ENABLE = 2;
  localparam int DCSW_S_TRIP = 3;
  localparam int DCSW_S_ERROR = 4;
  localparam int DCSW_S_UNUSED = 5;
  localparam int DCSW_S_TRIPLOCK = 6;
  localparam int DCSW_S_WARNING = 7;
  localparam int DCSW_S_SPEED_EQ = 8;
  localparam int DCSW_S_BUS_CTRL = 9;
  localparam int DCSW_S_FREQ_OK = 10;
  localparam int DCSW_S_IN_OP = 11;
  localparam int DCSW_S_OVERTEMP = 12;

  // Config register fields
  localparam int DCSW_F_RELAY1_SEL = 0;
  localparam int DCSW_F_RELAY2_SEL = 1;
  localparam int DCSW_F_MULTI_SETUP = 2;
  localparam int DCSW_F_REV_SRC_LO = 3;
  localparam int DCSW_F_LOCAL_SITE = 5;
  localparam int DCSW_F_SETUP_LO = 6;
  localparam int DCSW_CFG_BITS = 8;

  // Reset values
  localparam logic [15:0] DCSW_CMD_RESET = 16'h0000;
  localparam logic [7:0] DCSW_CFG_RESET = 8'h00;

  // Reversing source select
  typedef enum logic [1:0] {
    DCSW_REV_DIGITAL = 2'b00,
    DCSW_REV_BUS = 2'b01,
    DCSW_REV_OR = 2'b10,
    DCSW_REV_AND = 2'b11
  } dcsw_rev_src_type;

  // Bus slave states, one bit flips per step
  typedef enum logic {
    DCSW_BUS_IDLE = 1'b0,
    DCSW_BUS_ACK = 1'b1
  } dcsw_bus_state_type;
endpackage : dcsw_pkg

/* hw/dcsw_status.sv */
`timescale 1ns/10ps
module dcsw_status
  import dcsw_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tripped_i,
  input wire logic error_i,
  input wire logic triplock_i,
  input wire logic warning_i,
  input wire logic coast_active_i,
  input wire logic start_present_i,
  input wire logic bus_ctrl_ok_i,
  input wire logic overtemp_hold_i,
  input wire logic link_lost_i,
  input wire logic [FREQ_W-1:0] out_freq_i,
  input wire logic [FREQ_W-1:0] speed_ref_i,
  input wire logic [FREQ_W-1:0] freq_low_i,
  input wire logic [FREQ_W-1:0] freq_high_i,
  output logic [15:0] state_word_o
);
  logic [15:0] next_state_word;

  // Assemble the word; bits 13 to 15 are not reported here
  always_comb begin
    next_state_word = 16'h0000;
    next_state_word[DCSW_S_CTRL_READY] = ~tripped_i;
    next_state_word[DCSW_S_DRIVE_READY] = ~tripped_i & coast_active_i;
    next_state_word[DCSW_S_ENABLE] = ~coast_active_i;
    next_state_word[DCSW_S_TRIP] = tripped_i;
    next_state_word[DCSW_S_ERROR] = error_i;
    next_state_word[DCSW_S_UNUSED] = 1'b0;
    next_state_word[DCSW_S_TRIPLOCK] = triplock_i;
    next_state_word[DCSW_S_WARNING] = warning_i;
    next_state_word[DCSW_S_SPEED_EQ] = (out_freq_i == speed_ref_i);
    next_state_word[DCSW_S_BUS_CTRL] = bus_ctrl_ok_i;
    next_state_word[DCSW_S_FREQ_OK] = (out_freq_i > freq_low_i) &&
                                      (out_freq_i < freq_high_i);
    next_state_word[DCSW_S_IN_OP] = start_present_i | (|out_freq_i);
    next_state_word[DCSW_S_OVERTEMP] = overtemp_hold_i;
    // A dead option link must never leave stale good news behind
    if (link_lost_i) begin
      next_state_word = 16'h0000;
    end
  end

  // Registered so software reads a stable snapshot
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_word_o <= 16'h0000;
    end else begin
      state_word_o <= next_state_word;
    end
  end

  a_link_loss_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    link_lost_i |=> state_word_o == 16'h0000)
    else $error("state word not cleared on link loss");

  a_trip_status_bits: assert property (@(posedge clock_i) disable iff (rst_i)
    (tripped_i && !link_lost_i) |=> (!state_word_o[0] && state_word_o[3]))
    else $error("trip not shown in state word");

  a_unused_bit_zero: assert property (@(posedge clock_i) disable iff (rst_i)
    !state_word_o[DCSW_S_UNUSED])
    else $error("unused state bit set");
endmodule : dcsw_status

/* hw/dcsw_top.sv */
// Behaviour
// - Command bits 1:0 pick one of four presets
// - Bit 2 low gives DC brake then stop
// - Bit 3 low cuts output stage, coast
// - Bit 4 low ramps down with quick-stop time
// - Bit 5 low freezes output frequency
// - While frozen only coast or DC brake stop
// - Bit 6 low ramp stop, high permits start
// - Trip reset only on rising bit 7
// - Bit 8 high selects jog speed
// - Bit 9 chooses ramp pair one or two
// - Bit 10 low discards whole command word
// - Bits 11/12 drive relays when function selected
// - Bits 14:13 pick set-up in multi mode
// - Bit 15 reverses only for bus sources
// - State bit 0 ready, bit 1 coast-ready
// - State bit 2 shows motor enable
// - State bits 3, 4, 6 trip, error, lock
// - State bit 5 unused, bit 7 warning
// - State bit 8 speed equals reference
// - State bit 9 bus control possible
// - State bit 10 frequency within limits
// - State bit 11 running or start present
// - Link loss forces state word zero
// - State bit 12 overtemperature hold
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
module dcsw_top
  import dcsw_pkg::*;
#(
  parameter int FREQ_W = 16
) (
  input wire logic clock_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [3:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  // Digital inputs and drive conditions
  input wire logic coast_din_i,
  input wire logic dcbrake_din_i,
  input wire logic reverse_din_i,
  input wire logic local_stop_i,
  input wire logic tripped_i,
  input wire logic error_i,
  input wire logic triplock_i,
  input wire logic warning_i,
  input wire logic overtemp_hold_i,
  input wire logic link_lost_i,
  input wire logic [FREQ_W-1:0] out_freq_i,
  input wire logic [FREQ_W-1:0] speed_ref_i,
  input wire logic [FREQ_W-1:0] freq_low_i,
  input wire logic [FREQ_W-1:0] freq_high_i,
  // Decoded drive commands
  output logic [1:0] preset_sel_o,
  output logic dc_brake_o,
  output logic coast_o,
  output logic quick_stop_o,
  output logic freeze_o,
  output logic ramp_stop_o,
  output logic start_enable_o,
  output logic trip_reset_o,
  output logic jog_o,
  output logic ramp2_sel_o,
  output logic relay1_o,
  output logic relay2_o,
  output logic [1:0] setup_sel_o,
  output logic reverse_o
);
  dcsw_bus_state_type bus_state;
  logic [15:0] cmd_word;
  logic [DCSW_CFG_BITS-1:0] cfg;
  logic [15:0] state_word;
  logic bus_locked;
  logic cmd_take;
  logic cfg_take;
  logic bus_done;
  logic coast_active;
  logic dc_active;
  logic qstop_req;
  logic rstop_req;
  logic [31:0] next_readdata;
  dcsw_rev_src_type rev_src;

  // Address match used by read mux and write strobes
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // Every request waits exactly one cycle; simple and fixed latency
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bus_state <= DCSW_BUS_IDLE;
    end else begin
      unique case (bus_state)
        DCSW_BUS_IDLE: begin
          if (read_i || write_i) begin
            bus_state <= DCSW_BUS_ACK;
          end
        end
        DCSW_BUS_ACK: begin
          bus_state <= DCSW_BUS_IDLE;
        end
      endcase
    end
  end

  assign waitrequest_o = (read_i || write_i) && (bus_state == DCSW_BUS_IDLE);
  assign bus_done = (bus_state == DCSW_BUS_ACK);

  // Local stop or local reference site shuts out bus commands
  assign bus_locked = local_stop_i | cfg[DCSW_F_LOCAL_SITE];

  // A command lands only on a finished write with the valid bit set
  assign cmd_take = bus_done && write_i && hit(address_i, DCSW_OFS_CMD) &&
                    writedata_i[DCSW_C_VALID] && !bus_locked;
  assign cfg_take = bus_done && write_i && hit(address_i, DCSW_OFS_CFG);

  // Command word storage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cmd_word <= DCSW_CMD_RESET;
    end else if (cmd_take) begin
      cmd_word <= writedata_i[15:0];
    end
  end

  // Configuration storage
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cfg <= DCSW_CFG_RESET;
    end else if (cfg_take) begin
      cfg <= writedata_i[DCSW_CFG_BITS-1:0];
    end
  end

  // Trip reset pulse; compare against the previously accepted word
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      trip_reset_o <= 1'b0;
    end else begin
      trip_reset_o <= cmd_take && writedata_i[DCSW_C_RESET] &&
                      !cmd_word[DCSW_C_RESET];
    end
  end

  // Stop sources; coast and DC brake combine bus and digital inputs
  assign coast_active = !cmd_word[DCSW_C_NO_COAST] || coast_din_i;
  assign dc_active = !cmd_word[DCSW_C_RAMP_NOT_DC] || dcbrake_din_i;
  assign qstop_req = !cmd_word[DCSW_C_NO_QSTOP];
  assign rstop_req = !cmd_word[DCSW_C_START];
  assign rev_src = dcsw_rev_src_type'(cfg[DCSW_F_REV_SRC_LO +: 2]);

  // Decoded commands; registered so the drive sees clean levels
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      preset_sel_o <= 2'h0;
      dc_brake_o <= 1'b0;
      coast_o <= 1'b1;
      quick_stop_o <= 1'b0;
      freeze_o <= 1'b0;
      ramp_stop_o <= 1'b0;
      start_enable_o <= 1'b0;
      jog_o <= 1'b0;
      ramp2_sel_o <= 1'b0;
    end else begin
      preset_sel_o <= cmd_word[DCSW_C_PRESET_HI:DCSW_C_PRESET_LO];
      dc_brake_o <= dc_active;
      coast_o <= coast_active;
      freeze_o <= !cmd_word[DCSW_C_NO_FREEZE];
      // Frozen output ignores quick and ramp stops
      quick_stop_o <= qstop_req && cmd_word[DCSW_C_NO_FREEZE];
      ramp_stop_o <= rstop_req && cmd_word[DCSW_C_NO_FREEZE];
      start_enable_o <= !rstop_req && !coast_active && !dc_active &&
                        !qstop_req;
      jog_o <= cmd_word[DCSW_C_JOG];
      ramp2_sel_o <= cmd_word[DCSW_C_RAMP2];
    end
  end

  // Relays follow the word only when their function selects it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      relay1_o <= 1'b0;
      relay2_o <= 1'b0;
    end else begin
      if (cfg[DCSW_F_RELAY1_SEL]) begin
        relay1_o <= cmd_word[DCSW_C_RELAY1];
      end
      if (cfg[DCSW_F_RELAY2_SEL]) begin
        relay2_o <= cmd_word[DCSW_C_RELAY2];
      end
    end
  end

  // Set-up choice: bus bits in multi mode, else the fixed field
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      setup_sel_o <= 2'h0;
    end else if (cfg[DCSW_F_MULTI_SETUP]) begin
      setup_sel_o <= cmd_word[DCSW_C_SETUP_HI:DCSW_C_SETUP_LO];
    end else begin
      setup_sel_o <= cfg[DCSW_F_SETUP_LO +: 2];
    end
  end

  // Reversing source gates the bus bit against the digital input
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      reverse_o <= 1'b0;
    end else begin
      unique case (rev_src)
        DCSW_REV_DIGITAL: reverse_o <= reverse_din_i;
        DCSW_REV_BUS: reverse_o <= cmd_word[DCSW_C_REVERSE];
        DCSW_REV_OR: reverse_o <= cmd_word[DCSW_C_REVERSE] | reverse_din_i;
        DCSW_REV_AND: reverse_o <= cmd_word[DCSW_C_REVERSE] & reverse_din_i;
      endcase
    end
  end

  // Status word assembly
  dcsw_status #(
    .FREQ_W(FREQ_W)
  ) u_status (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .tripped_i(tripped_i),
    .error_i(error_i),
    .triplock_i(triplock_i),
    .warning_i(warning_i),
    .coast_active_i(coast_active),
    .start_present_i(start_enable_o),
    .bus_ctrl_ok_i(!bus_locked),
    .overtemp_hold_i(overtemp_hold_i),
    .link_lost_i(link_lost_i),
    .out_freq_i(out_freq_i),
    .speed_ref_i(speed_ref_i),
    .freq_low_i(freq_low_i),
    .freq_high_i(freq_high_i),
    .state_word_o(state_word)
  );

  // Read mux; command word is write-only and reads zero
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hit(address_i, DCSW_OFS_STATE)) begin
      next_readdata = {16'h0000, state_word};
    end else if (hit(address_i, DCSW_OFS_CFG)) begin
      next_readdata = {{(32 - DCSW_CFG_BITS){1'b0}}, cfg};
    end
  end

  // Captured in the waiting cycle so data stands at the release edge
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i && bus_state == DCSW_BUS_IDLE) begin
      readdata_o <= next_readdata;
    end
  end

  a_bus_one_wait: assert property (@(posedge clock_i) disable iff (rst_i)
    (write_i || read_i) && waitrequest_o |=> !waitrequest_o)
    else $error("waitrequest held longer than one cycle");

  a_invalid_word_ignored: assert property (@(posedge clock_i) disable iff (rst_i)
    (bus_done && write_i && hit(address_i, DCSW_OFS_CMD) && !writedata_i[DCSW_C_VALID])
    |=> $stable(cmd_word))
    else $error("command word taken with valid bit low");

  a_preset_follows: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_take |=> ##1 preset_sel_o == $past(writedata_i[1:0], 2))
    else $error("preset select does not follow command");

  a_coast_cuts_output: assert property (@(posedge clock_i) disable iff (rst_i)
    (cmd_take && !writedata_i[DCSW_C_NO_COAST]) |=> ##1 (coast_o && !start_enable_o))
    else $error("coast bit did not cut output");

  a_reset_edge_only: assert property (@(posedge clock_i) disable iff (rst_i)
    trip_reset_o |-> $past(cmd_take) && $past(!cmd_word[DCSW_C_RESET])
    ##1 !trip_reset_o)
    else $error("trip reset without rising edge or too long");

  a_freeze_blocks_stops: assert property (@(posedge clock_i) disable iff (rst_i)
    freeze_o |-> (!quick_stop_o && !ramp_stop_o))
    else $error("quick or ramp stop while frozen");

  a_reverse_digital: assert property (@(posedge clock_i) disable iff (rst_i)
    (rev_src == DCSW_REV_DIGITAL) |=> reverse_o == $past(reverse_din_i))
    else $error("reverse not from digital input");

  a_local_blocks_bus: assert property (@(posedge clock_i) disable iff (rst_i)
    bus_locked |-> !cmd_take)
    else $error("bus command accepted while local");

  a_relay_gated: assert property (@(posedge clock_i) disable iff (rst_i)
    !cfg[DCSW_F_RELAY1_SEL] |=> $stable(relay1_o))
    else $error("relay moved without function select");

  // Decoded levels show two edges after the write that carried them
  a_dc_brake_bit: assert property (@(posedge clock_i) disable iff (rst_i)
    (cmd_take && !writedata_i[DCSW_C_RAMP_NOT_DC]) |=> ##1 dc_brake_o)
    else $error("DC brake bit did not brake");

  a_quick_stop_bit: assert property (@(posedge clock_i) disable iff (rst_i)
    (cmd_take && !writedata_i[DCSW_C_NO_QSTOP] && writedata_i[DCSW_C_NO_FREEZE])
    |=> ##1 quick_stop_o)
    else $error("quick stop bit did not stop");

  a_freeze_follows: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_take |=> ##1 freeze_o == !$past(writedata_i[DCSW_C_NO_FREEZE], 2))
    else $error("freeze does not follow command");

  a_ramp_stop_bit: assert property (@(posedge clock_i) disable iff (rst_i)
    (cmd_take && !writedata_i[DCSW_C_START] && writedata_i[DCSW_C_NO_FREEZE])
    |=> ##1 (ramp_stop_o && !start_enable_o))
    else $error("ramp stop bit did not stop");

  a_trip_pulse_edge: assert property (@(posedge clock_i) disable iff (rst_i)
    (cmd_take && writedata_i[DCSW_C_RESET] && !cmd_word[DCSW_C_RESET]) |=> trip_reset_o)
    else $error("rising reset bit gave no pulse");

  a_jog_ramp_follow: assert property (@(posedge clock_i) disable iff (rst_i)
    cmd_take |=> ##1 {jog_o, ramp2_sel_o} ==
      {$past(writedata_i[DCSW_C_JOG], 2), $past(writedata_i[DCSW_C_RAMP2], 2)})
    else $error("jog or ramp pair does not follow command");

  a_relay2_gated: assert property (@(posedge clock_i) disable iff (rst_i)
    !cfg[DCSW_F_RELAY2_SEL] |=> $stable(relay2_o))
    else $error("relay two moved without function select");

  a_setup_multi: assert property (@(posedge clock_i) disable iff (rst_i)
    cfg[DCSW_F_MULTI_SETUP] |=>
      setup_sel_o == $past(cmd_word[DCSW_C_SETUP_HI:DCSW_C_SETUP_LO]))
    else $error("set-up not taken from command in multi mode");

  a_reverse_bus: assert property (@(posedge clock_i) disable iff (rst_i)
    (rev_src == DCSW_REV_BUS) |=> reverse_o == $past(cmd_word[DCSW_C_REVERSE]))
    else $error("reverse not from bus bit");

  c_trip_reset: cover property (@(posedge clock_i) disable iff (rst_i) trip_reset_o);
  c_frozen_run: cover property (@(posedge clock_i) disable iff (rst_i)
    freeze_o && start_enable_o);
  c_reverse_bus: cover property (@(posedge clock_i) disable iff (rst_i)
    rev_src == DCSW_REV_BUS && reverse_o);
  c_frozen_coast: cover property (@(posedge clock_i) disable iff (rst_i)
    freeze_o && coast_o);
  c_local_refused: cover property (@(posedge clock_i) disable iff (rst_i)
    bus_done && write_i && bus_locked);
endmodule : dcsw_top

/* test/dcsw_master.sv */
`timescale 1ns/10ps
module dcsw_master (
  input wire logic clock_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [3:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o
);
  // Bus idle from time zero
  initial begin
    address_o = 4'h0;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0000_0000;
  end

  // One whole 32-bit transfer, held until waitrequest is seen low
  task xfer(input logic rd, input logic [3:0] addr, input logic [31:0] wdata,
            output logic [31:0] rdata);
    logic busy;
    @(posedge clock_i);
    address_o <= addr;
    read_o <= rd;
    write_o <= !rd;
    writedata_o <= wdata;
    do begin
      // Sampled at the rising edge, before the slave's own update lands
      @(posedge clock_i);
      busy = waitrequest_i;
      rdata = readdata_i;
    end while (busy);
    read_o <= 1'b0;
    write_o <= 1'b0;
    // Released lines must not keep showing the old request
    address_o <= ~addr;
    writedata_o <= ~wdata;
  endtask : xfer
endmodule : dcsw_master

/* test/drive_control_status_word_test.sv */
`timescale 1ns/10ps
module drive_control_status_word_test
  import dcsw_pkg::*;
;
  logic clock_i, rst_i, read_i, write_i, waitrequest_o;
  logic [3:0] address_i;
  logic [31:0] writedata_i, readdata_o, r;
  logic coast_din_i, dcbrake_din_i, reverse_din_i, local_stop_i, tripped_i, error_i;
  logic triplock_i, warning_i, overtemp_hold_i, link_lost_i;
  logic [15:0] out_freq_i, speed_ref_i, freq_low_i, freq_high_i;
  logic [1:0] preset_sel_o, setup_sel_o;
  logic dc_brake_o, coast_o, quick_stop_o, freeze_o, ramp_stop_o, start_enable_o;
  logic trip_reset_o, jog_o, ramp2_sel_o, relay1_o, relay2_o, reverse_o;
  logic [7:0] drv_bits;
  int err_count = 0;
  int compares = 0;
  int pulses = 0;
  logic [15:0] dw [3] = '{16'h077C, 16'h0400, 16'h0420};
  logic [7:0] de [3] = '{8'h07, 8'hD0, 8'hE8};
  logic [15:0] tw [6] = '{16'h0400, 16'h0480, 16'h0480, 16'h0400, 16'h0080, 16'h0480};

  assign drv_bits = {dc_brake_o, coast_o, quick_stop_o, freeze_o, ramp_stop_o,
                     start_enable_o, jog_o, ramp2_sel_o};

  dcsw_top dut (.clock_i(clock_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .coast_din_i(coast_din_i), .dcbrake_din_i(dcbrake_din_i),
    .reverse_din_i(reverse_din_i), .local_stop_i(local_stop_i), .tripped_i(tripped_i),
    .error_i(error_i), .triplock_i(triplock_i), .warning_i(warning_i),
    .overtemp_hold_i(overtemp_hold_i), .link_lost_i(link_lost_i), .out_freq_i(out_freq_i),
    .speed_ref_i(speed_ref_i), .freq_low_i(freq_low_i), .freq_high_i(freq_high_i),
    .preset_sel_o(preset_sel_o), .dc_brake_o(dc_brake_o), .coast_o(coast_o),
    .quick_stop_o(quick_stop_o), .freeze_o(freeze_o), .ramp_stop_o(ramp_stop_o),
    .start_enable_o(start_enable_o), .trip_reset_o(trip_reset_o), .jog_o(jog_o),
    .ramp2_sel_o(ramp2_sel_o), .relay1_o(relay1_o), .relay2_o(relay2_o),
    .setup_sel_o(setup_sel_o), .reverse_o(reverse_o));

  dcsw_master u_master (.clock_i(clock_i), .waitrequest_i(waitrequest_o),
    .readdata_i(readdata_o), .address_o(address_i), .read_o(read_i), .write_o(write_i),
    .writedata_o(writedata_i));

  // 50 ns clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  // Count one-cycle trip reset pulses
  always @(posedge clock_i) begin
    if (trip_reset_o === 1'b1) pulses <= pulses + 1;
  end

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task finish_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_master.xfer(1'b0, a, d, x);
  endtask : wr

  task rd(input logic [3:0] a, output logic [31:0] d);
    u_master.xfer(1'b1, a, 32'h0000_0000, d);
  endtask : rd

  // Command write, then let decoded outputs land
  task cmd(input logic [15:0] w);
    wr(DCSW_OFS_CMD, {16'h0000, w});
    repeat (2) @(negedge clock_i);
  endtask : cmd

  // Drive conditions, then read the state word after its one-cycle lag
  task cond(input logic [4:0] c, input logic [15:0] f, input logic ls, input logic ll);
    @(posedge clock_i);
    {tripped_i, error_i, triplock_i, warning_i, overtemp_hold_i} <= c;
    out_freq_i <= f;
    local_stop_i <= ls;
    link_lost_i <= ll;
    repeat (2) @(negedge clock_i);
    rd(DCSW_OFS_STATE, r);
  endtask : cond

  // Hang guard, far beyond the 130 or so cycles the tests need
  initial begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    finish_test();
  end

  // Main sequence
  initial begin
    rst_i = 1'b1;
    {coast_din_i, dcbrake_din_i, reverse_din_i, local_stop_i, link_lost_i} = 5'h00;
    {tripped_i, error_i, triplock_i, warning_i, overtemp_hold_i} = 5'h00;
    out_freq_i = 16'h0000;
    speed_ref_i = 16'h0064;
    freq_low_i = 16'h000A;
    freq_high_i = 16'h00C8;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(negedge clock_i);
    check("coast", coast_o, 1);
    check("dc_brake", dc_brake_o, 1);
    rd(4'hC, r);
    check("unmapped", r, 0);
    $display("test reset done");
    wr(DCSW_OFS_CFG, 32'h0000_0004);
    for (int i = 0; i < 4; i++) begin
      cmd(16'h077C | 16'(i) | 16'(i << 13));
      check("preset", preset_sel_o, i);
      check("setup", setup_sel_o, i);
    end
    cmd(16'h0000);
    check("invalid word", {preset_sel_o, drv_bits}, 10'h307);
    @(posedge clock_i);
    local_stop_i <= 1'b1;
    cmd(16'h0400);
    check("local stop", drv_bits, 8'h07);
    @(posedge clock_i);
    local_stop_i <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      cmd(dw[i]);
      check("drive bits", drv_bits, de[i]);
    end
    $display("test decode done");
    for (int i = 0; i < 6; i++) cmd(tw[i]);
    check("trip resets", pulses, 2);
    $display("test trip reset done");
    wr(DCSW_OFS_CFG, 32'h0000_000D);
    cmd(16'h9C00);
    check("relay reverse", {relay1_o, relay2_o, reverse_o}, 3'b101);
    wr(DCSW_OFS_CFG, 32'h0000_0000);
    cmd(16'hF400);
    check("relay reverse", {relay1_o, relay2_o, reverse_o}, 3'b100);
    check("fixed setup", setup_sel_o, 0);
    $display("test relay done");
    cond(5'h1F, 16'h0064, 1'b0, 1'b0);
    check("state busy", r, 32'h0000_1FD8);
    cond(5'h00, 16'h00C8, 1'b1, 1'b0);
    check("state clear", r, 32'h0000_0803);
    cond(5'h1F, 16'h0064, 1'b0, 1'b1);
    check("state lost", r, 32'h0000_0000);
    $display("test state done");
    // Reverse in AND and OR modes, frozen run, digital coast, local site
    @(posedge clock_i);
    reverse_din_i <= 1'b1;
    wr(DCSW_OFS_CFG, 32'h0000_0018);
    cmd(16'h045C);
    check("rev and", reverse_o, 0);
    wr(DCSW_OFS_CFG, 32'h0000_0010);
    cmd(16'h045C);
    check("rev or", reverse_o, 1);
    check("frozen run", drv_bits, 8'h14);
    cond(5'h00, 16'h0064, 1'b0, 1'b0);
    check("state run", r, 32'h0000_0F05);
    @(posedge clock_i);
    coast_din_i <= 1'b1;
    repeat (2) @(negedge clock_i);
    check("frozen coast", drv_bits, 8'h50);
    wr(DCSW_OFS_CFG, 32'h0000_0030);
    cmd(16'h0400);
    check("local site", drv_bits, 8'h50);
    $display("test drive inputs done");
    finish_test();
  end
endmodule : drive_control_status_word_test
